// >>> rtl/psc_pkg.sv
// Shared constants, types and helpers for the pressure setpoint control block
package psc_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * (CLK_HZ / 1000000);
  localparam int SHOW_MS = 2000;
  localparam int HOLD_MS = 5000;
  localparam int SLOW_MS = 500;
  localparam int FAST_MS = 100;
  localparam logic [12:0] SHOW_LAST = 13'(SHOW_MS * 1000 / TICK_US - 1);
  localparam logic [12:0] HOLD_LAST = 13'(HOLD_MS * 1000 / TICK_US - 1);
  localparam logic [12:0] SLOW_LAST = 13'(SLOW_MS * 1000 / TICK_US - 1);
  localparam logic [12:0] FAST_LAST = 13'(FAST_MS * 1000 / TICK_US - 1);
  // ==========================================================
  // Pressure word: mantissa 10..99 (0 is zero), signed exponent
  localparam int SP_W = 13;
  localparam logic [6:0] MANT_ZERO = 7'h00;
  localparam logic [6:0] MANT_MIN = 7'h0a;
  localparam logic [6:0] MANT_MAX = 7'h63;
  localparam logic [5:0] EXP_MIN = 6'h34;
  localparam logic [5:0] EXP_MAX = 6'h05;
  localparam int KEY_EXP_BIAS = 12;
  localparam int KEY_DECADE = 90;
  localparam int KEY_MANT_OFS = 9;
  localparam logic [11:0] HYST_STEPS = 12'h005;
  localparam logic [SP_W-1:0] SP_RESET = 13'h0000;
  // ==========================================================
  // Channels and switches
  localparam int NCH = 6;
  localparam logic [2:0] CH_FIRST = 3'h1;
  localparam logic [2:0] CH_LAST = 3'h6;
  localparam logic [2:0] CH_ION_LAST = 3'h2;
  localparam logic [2:0] CH_A_LAST = 3'h4;
  localparam logic [2:0] SCAN_LAST = 3'h5;
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_ON = 2'h1;
  localparam logic [1:0] AUTO_SET = 2'h2;
  typedef enum logic [1:0] {
    PSC_SRC_PRESS = 2'h0,
    PSC_SRC_TURNON = 2'h1,
    PSC_SRC_SETPT = 2'h2
  } psc_src_type;
  typedef enum logic [2:0] {
    UI_IDLE = 3'h0,
    UI_LOAD = 3'h1,
    UI_FETCH = 3'h2,
    UI_HOLD = 3'h3,
    UI_SCROLL = 3'h4,
    UI_SHOW = 3'h5
  } psc_ui_type;
  // ==========================================================
  // Helpers
  function automatic logic [11:0] psc_key(input logic [6:0] m, input logic [5:0] e);
    int k;
    k = 0;
    if (m != MANT_ZERO) begin
      k = (int'($signed(e)) + KEY_EXP_BIAS) * KEY_DECADE + int'(m) - KEY_MANT_OFS;
    end
    return 12'(k);
  endfunction
  function automatic logic [13:0] psc_step(input logic [6:0] m, input logic [5:0] e,
                                           input logic up);
    logic [6:0] nm;
    logic [5:0] ne;
    logic cr;
    nm = m;
    ne = e;
    cr = 1'b0;
    if (up) begin
      if (m == MANT_ZERO) begin
        nm = MANT_MIN;
        ne = EXP_MIN;
      end else if (m < MANT_MAX) begin
        nm = m + 7'h01;
      end else if ($signed(e) < $signed(EXP_MAX)) begin
        nm = MANT_MIN;
        ne = e + 6'h01;
        cr = 1'b1;
      end
    end else begin
      if (m > MANT_MIN) begin
        nm = m - 7'h01;
      end else if (m == MANT_ZERO) begin
        nm = MANT_ZERO;
      end else if ($signed(e) > $signed(EXP_MIN)) begin
        nm = MANT_MAX;
        ne = e - 6'h01;
        cr = 1'b1;
      end else begin
        nm = MANT_ZERO;
      end
    end
    return {cr, nm, ne};
  endfunction
endpackage

// >>> rtl/psc_spmem.sv
// Setpoint store, one word per process channel, registered read
`timescale 1ns/1ns
module psc_spmem import psc_pkg::*; (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [SP_W-1:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [SP_W-1:0] rd_data
);
  logic [SP_W-1:0] mem [NCH];

  // ==========================================================
  // Power-up content
  initial begin
    for (int i = 0; i < NCH; i++) begin
      mem[i] = SP_RESET;
    end
  end

  // ==========================================================
  // Write and read ports
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// >>> rtl/psc_top.sv
// Ion gauge auto on/off and process setpoint relays with setpoint editing
// Functional notes
// - Thermal A drives gauge one, B drives two
// - Request turn-on when thermal pressure drops below
// - Auto turn-off above threshold unless already tripped
// - One action per crossing, manual off respected
// - Set position shows turn-on pressure on A for gauge one, B for two
// - Off position disables automatic on and off
// - Setpoints stored as mantissa and exponent
// - Setpoint range 1.0e-12 up to 9.9e+5
// - Compare setpoint with displayed value, no conversion
// - Setpoint above atmosphere keeps relay active
// - Zero setpoint keeps relay inactive
// - Manual override holds relay state
// - Brief press shows chosen setpoint two seconds
// - Channels 1-2 ion line, 3-4 A, 5-6 B
// - Held five seconds, setpoint scrolls until release
// - Slow scroll, fast after decade, fresh press slow
// - Two seconds after release commit and revert
`timescale 1ns/1ns
module psc_top import psc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic set_up_btn,
  input wire logic set_dn_btn,
  input wire logic [2:0] chan_sel,
  input wire logic [1:0] auto_sw_one,
  input wire logic [1:0] auto_sw_two,
  input wire logic [5:0] relay_ovr_en,
  input wire logic [5:0] relay_ovr_state,
  input wire logic [5:0] relay_rev_pol,
  input wire logic [6:0] ion_line_mant,
  input wire logic [5:0] ion_line_exp,
  input wire logic [6:0] line_a_mant,
  input wire logic [5:0] line_a_exp,
  input wire logic [6:0] line_b_mant,
  input wire logic [5:0] line_b_exp,
  input wire logic [6:0] turn_on_one_mant,
  input wire logic [5:0] turn_on_one_exp,
  input wire logic [6:0] turn_on_two_mant,
  input wire logic [5:0] turn_on_two_exp,
  input wire logic ion_gauge_one_on,
  input wire logic ion_gauge_two_on,
  output logic [1:0] auto_on_req,
  output logic [1:0] auto_off_req,
  output logic [5:0] relay,
  output logic [1:0] ion_line_src,
  output logic [6:0] ion_line_out_mant,
  output logic [5:0] ion_line_out_exp,
  output logic [1:0] line_a_src,
  output logic [6:0] line_a_out_mant,
  output logic [5:0] line_a_out_exp,
  output logic [1:0] line_b_src,
  output logic [6:0] line_b_out_mant,
  output logic [5:0] line_b_out_exp
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [26:0] pin_raw;
  logic [26:0] pin_s1;
  logic [26:0] pin_s2;
  logic up_s;
  logic dn_s;
  logic [2:0] chan_s;
  logic [1:0] sw_one;
  logic [1:0] sw_two;
  logic [5:0] ovr_en;
  logic [5:0] ovr_st;
  logic [5:0] rev_pol;
  logic [14:0] tick_cnt;
  logic tick;
  logic [11:0] tg_key [2];
  logic [11:0] on_key [2];
  logic [1:0] below;
  logic [1:0] above;
  logic [1:0] auto_en;
  logic [1:0] gauge_on;
  logic [1:0] side_below;
  psc_ui_type ui_state;
  logic [2:0] ui_chan;
  logic [6:0] work_mant;
  logic [5:0] work_exp;
  logic edited;
  logic dir_up;
  logic fast;
  logic [12:0] ms_cnt;
  logic btn_any;
  logic btn_prev;
  logic press;
  logic chan_ok;
  logic showing;
  logic [13:0] next_step;
  logic mem_wr;
  logic [2:0] wr_addr;
  logic [2:0] rd_addr;
  logic [SP_W-1:0] rd_data;
  logic [2:0] scan_ptr;
  logic [2:0] scan_addr;
  logic scan_vld;
  logic [11:0] sp_key;
  logic [11:0] disp_key;
  logic cmp_raw;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Reset release and pin synchronisers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign pin_raw = {set_up_btn, set_dn_btn, chan_sel, auto_sw_one, auto_sw_two,
                    relay_ovr_en, relay_ovr_state, relay_rev_pol};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 27'h0000000;
      pin_s2 <= 27'h0000000;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end
  assign up_s = pin_s2[26];
  assign dn_s = pin_s2[25];
  assign chan_s = pin_s2[24:22];
  assign sw_one = pin_s2[21:20];
  assign sw_two = pin_s2[19:18];
  assign ovr_en = pin_s2[17:12];
  assign ovr_st = pin_s2[11:6];
  assign rev_pol = pin_s2[5:0];

  // ==========================================================
  // Millisecond tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 15'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == 15'(TICK_CYCLES - 1)) begin
      tick_cnt <= 15'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 15'h0001;
      tick <= 1'b0;
    end
  end

  // ==========================================================
  // Ion gauge automatic on/off
  always_comb begin
    tg_key[0] = psc_key(line_a_mant, line_a_exp);
    tg_key[1] = psc_key(line_b_mant, line_b_exp);
    on_key[0] = psc_key(turn_on_one_mant, turn_on_one_exp);
    on_key[1] = psc_key(turn_on_two_mant, turn_on_two_exp);
    for (int g = 0; g < 2; g++) begin
      below[g] = tg_key[g] < on_key[g];
      above[g] = tg_key[g] > on_key[g] + HYST_STEPS;
    end
    auto_en[0] = sw_one == AUTO_ON;
    auto_en[1] = sw_two == AUTO_ON;
    gauge_on = {ion_gauge_two_on, ion_gauge_one_on};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      side_below <= 2'h0;
      auto_on_req <= 2'h0;
      auto_off_req <= 2'h0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        auto_on_req[g] <= 1'b0;
        auto_off_req[g] <= 1'b0;
        if (below[g] && !side_below[g]) begin
          side_below[g] <= 1'b1;
          auto_on_req[g] <= auto_en[g];
        end else if (above[g] && side_below[g]) begin
          side_below[g] <= 1'b0;
          auto_off_req[g] <= auto_en[g] && gauge_on[g];
        end
      end
    end
  end

  // ==========================================================
  // Setpoint button and thumbwheel sequence
  assign btn_any = up_s || dn_s;
  assign press = btn_any && !btn_prev;
  assign chan_ok = chan_s >= CH_FIRST && chan_s <= CH_LAST;
  assign showing = ui_state == UI_HOLD || ui_state == UI_SCROLL || ui_state == UI_SHOW;
  assign next_step = psc_step(work_mant, work_exp, dir_up);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_prev <= 1'b0;
    end else begin
      btn_prev <= btn_any;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ui_state <= UI_IDLE;
      ui_chan <= CH_FIRST;
      work_mant <= MANT_ZERO;
      work_exp <= EXP_MIN;
      edited <= 1'b0;
      dir_up <= 1'b0;
      fast <= 1'b0;
      ms_cnt <= 13'h0000;
      mem_wr <= 1'b0;
    end else begin
      mem_wr <= 1'b0;
      case (ui_state)
        UI_IDLE: begin
          if (press && chan_ok) begin
            ui_chan <= chan_s;
            edited <= 1'b0;
            ui_state <= UI_LOAD;
          end
        end
        UI_LOAD: begin
          ui_state <= UI_FETCH;
        end
        UI_FETCH: begin
          work_mant <= rd_data[12:6];
          work_exp <= rd_data[5:0];
          dir_up <= up_s;
          ms_cnt <= 13'h0000;
          ui_state <= UI_HOLD;
        end
        UI_HOLD: begin
          if (!btn_any) begin
            ms_cnt <= 13'h0000;
            ui_state <= UI_SHOW;
          end else if (tick) begin
            if (ms_cnt == HOLD_LAST) begin
              ms_cnt <= 13'h0000;
              fast <= 1'b0;
              ui_state <= UI_SCROLL;
            end else begin
              ms_cnt <= ms_cnt + 13'h0001;
            end
          end
        end
        UI_SCROLL: begin
          if (!btn_any) begin
            ms_cnt <= 13'h0000;
            ui_state <= UI_SHOW;
          end else if (tick) begin
            if (ms_cnt == (fast ? FAST_LAST : SLOW_LAST)) begin
              ms_cnt <= 13'h0000;
              work_mant <= next_step[12:6];
              work_exp <= next_step[5:0];
              edited <= 1'b1;
              fast <= fast || next_step[13];
            end else begin
              ms_cnt <= ms_cnt + 13'h0001;
            end
          end
        end
        UI_SHOW: begin
          if (press) begin
            dir_up <= up_s;
            ms_cnt <= 13'h0000;
            fast <= 1'b0;
            ui_state <= edited ? UI_SCROLL : UI_HOLD;
          end else if (tick) begin
            if (ms_cnt == SHOW_LAST) begin
              mem_wr <= edited;
              ui_state <= UI_IDLE;
            end else begin
              ms_cnt <= ms_cnt + 13'h0001;
            end
          end
        end
        default: begin
          ui_state <= UI_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Setpoint store and relay scan
  assign wr_addr = ui_chan - CH_FIRST;
  assign rd_addr = (ui_state == UI_LOAD) ? wr_addr : scan_ptr;

  psc_spmem u_spmem (
    .clk(core_clk),
    .wr_en(mem_wr),
    .wr_addr(wr_addr),
    .wr_data({work_mant, work_exp}),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_ptr <= 3'h0;
      scan_addr <= 3'h0;
      scan_vld <= 1'b0;
    end else begin
      scan_vld <= ui_state != UI_LOAD;
      scan_addr <= scan_ptr;
      if (ui_state != UI_LOAD) begin
        scan_ptr <= (scan_ptr == SCAN_LAST) ? 3'h0 : scan_ptr + 3'h1;
      end
    end
  end

  always_comb begin
    sp_key = psc_key(rd_data[12:6], rd_data[5:0]);
    if (scan_addr < CH_ION_LAST) begin
      disp_key = psc_key(ion_line_mant, ion_line_exp);
    end else if (scan_addr < CH_A_LAST) begin
      disp_key = psc_key(line_a_mant, line_a_exp);
    end else begin
      disp_key = psc_key(line_b_mant, line_b_exp);
    end
    cmp_raw = disp_key < sp_key;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay <= 6'h00;
    end else if (scan_vld) begin
      if (ovr_en[scan_addr]) begin
        relay[scan_addr] <= ovr_st[scan_addr];
      end else begin
        relay[scan_addr] <= cmp_raw ^ rev_pol[scan_addr];
      end
    end
  end

  // ==========================================================
  // Display line sources
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ion_line_src <= PSC_SRC_PRESS;
      ion_line_out_mant <= MANT_ZERO;
      ion_line_out_exp <= EXP_MIN;
      line_a_src <= PSC_SRC_PRESS;
      line_a_out_mant <= MANT_ZERO;
      line_a_out_exp <= EXP_MIN;
      line_b_src <= PSC_SRC_PRESS;
      line_b_out_mant <= MANT_ZERO;
      line_b_out_exp <= EXP_MIN;
    end else begin
      if (showing && ui_chan <= CH_ION_LAST) begin
        ion_line_src <= PSC_SRC_SETPT;
        {ion_line_out_mant, ion_line_out_exp} <= {work_mant, work_exp};
      end else begin
        ion_line_src <= PSC_SRC_PRESS;
        {ion_line_out_mant, ion_line_out_exp} <= {ion_line_mant, ion_line_exp};
      end
      if (sw_one == AUTO_SET) begin
        line_a_src <= PSC_SRC_TURNON;
        {line_a_out_mant, line_a_out_exp} <= {turn_on_one_mant, turn_on_one_exp};
      end else if (showing && ui_chan > CH_ION_LAST && ui_chan <= CH_A_LAST) begin
        line_a_src <= PSC_SRC_SETPT;
        {line_a_out_mant, line_a_out_exp} <= {work_mant, work_exp};
      end else begin
        line_a_src <= PSC_SRC_PRESS;
        {line_a_out_mant, line_a_out_exp} <= {line_a_mant, line_a_exp};
      end
      if (sw_two == AUTO_SET) begin
        line_b_src <= PSC_SRC_TURNON;
        {line_b_out_mant, line_b_out_exp} <= {turn_on_two_mant, turn_on_two_exp};
      end else if (showing && ui_chan > CH_A_LAST) begin
        line_b_src <= PSC_SRC_SETPT;
        {line_b_out_mant, line_b_out_exp} <= {work_mant, work_exp};
      end else begin
        line_b_src <= PSC_SRC_PRESS;
        {line_b_out_mant, line_b_out_exp} <= {line_b_mant, line_b_exp};
      end
    end
  end

  // ==========================================================
  // Checks
  a_on_req_cause: assert property (
    auto_on_req[0] |-> $past(below[0] && !side_below[0] && auto_en[0]))
    else $error("gauge one turn-on without crossing below");
  a_on_req_source: assert property (
    auto_on_req[1] |-> $past(tg_key[1] < on_key[1]))
    else $error("gauge two turn-on not from thermal B");
  a_off_req_cause: assert property (
    auto_off_req[0] |-> $past(above[0] && gauge_on[0] && auto_en[0]))
    else $error("gauge one turn-off without valid cause");
  a_once_per_cross: assert property (
    (side_below[0] && $past(side_below[0])) |-> !auto_on_req[0])
    else $error("repeated turn-on within one crossing");
  a_auto_disabled: assert property (
    !auto_en[1] |=> !auto_on_req[1] && !auto_off_req[1])
    else $error("automatic action while disabled");
  a_turnon_shown: assert property (
    (sw_one == AUTO_SET) |=> line_a_src == PSC_SRC_TURNON
      && line_a_out_mant == $past(turn_on_one_mant))
    else $error("turn-on pressure not shown on line A");
  a_hold_to_scroll: assert property (
    (ui_state == UI_HOLD && btn_any && tick && ms_cnt == HOLD_LAST) |=> ui_state == UI_SCROLL)
    else $error("scroll did not start after hold time");
  a_show_commit: assert property (
    (ui_state == UI_SHOW && !press && tick && ms_cnt == SHOW_LAST)
      |=> ui_state == UI_IDLE && mem_wr == $past(edited))
    else $error("display timeout or commit wrong");
  a_setpt_limits: assert property (
    mem_wr |-> work_mant == MANT_ZERO || (work_mant >= MANT_MIN && work_mant <= MANT_MAX))
    else $error("committed setpoint out of range");
  a_relay_zero: assert property (
    (scan_vld && rd_data[12:6] == MANT_ZERO && !ovr_en[scan_addr])
      |=> relay[$past(scan_addr)] == $past(rev_pol[scan_addr]))
    else $error("zero setpoint relay not inactive");
  a_relay_override: assert property (
    (scan_vld && ovr_en[scan_addr]) |=> relay[$past(scan_addr)] == $past(ovr_st[scan_addr]))
    else $error("override state not applied");
  a_ion_line_map: assert property (
    (showing && ui_chan <= CH_ION_LAST) |=> ion_line_src == PSC_SRC_SETPT)
    else $error("setpoint 1 or 2 not on ion line");

  c_auto_on: cover property (auto_on_req[0]);
  c_fast_scroll: cover property (ui_state == UI_SCROLL && fast);
  c_commit: cover property (mem_wr);
endmodule

// >>> test/psc_partner.sv
// Electrometer stand-in that turns ion gauges on and off on request
`timescale 1ns/1ns
module psc_partner (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [1:0] on_req,
  input wire logic [1:0] off_req,
  input wire logic [1:0] manual_off,
  output logic [1:0] gauge_on
);
  // ==========================================================
  // Gauge state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gauge_on <= 2'h0;
    end else begin
      gauge_on <= (gauge_on | on_req) & ~off_req & ~manual_off;
    end
  end
endmodule

// >>> test/tb_pressure_setpoint_control.sv
// Self-checking bench for the pressure setpoint control block
`timescale 1ns/1ns
module tb_pressure_setpoint_control;
  import psc_pkg::*;
  localparam int TK = 4;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic up = 1'b0;
  logic dn = 1'b0;
  logic [2:0] chan = 3'h1;
  logic [1:0] sw1 = AUTO_OFF;
  logic [1:0] sw2 = AUTO_OFF;
  logic [5:0] ov_en = 6'h00;
  logic [5:0] ov_st = 6'h00;
  logic [5:0] rev = 6'h00;
  logic [1:0] man_off = 2'h0;
  logic [1:0] on_req;
  logic [1:0] off_req;
  logic [1:0] g_on;
  logic [1:0] p_on = 2'h0;
  logic [1:0] p_off = 2'h0;
  logic [5:0] relay;
  logic [1:0] src [3];
  logic [6:0] om [3];
  logic [5:0] oe [3];
  int lm [3] = '{50, 50, 50};
  int le [3] = '{-1, -1, -1};
  int spm [7] = '{default: 0};
  int spe [7] = '{default: 0};
  int non [2] = '{0, 0};
  int noff [2] = '{0, 0};
  int eon [2] = '{0, 0};
  int eoff [2] = '{0, 0};
  int flag [2] = '{0, 0};
  int tm [10] = '{49, 52, 55, 56, 40, 45, 60, 40, 60, 40};
  int failures = 0;
  int checks_done = 0;
  int seed = 66410;
  int el;
  int ln;
  // ==========================================================
  // Design and partner
  psc_top #(.TICK_CYCLES(TK)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .set_up_btn(up), .set_dn_btn(dn), .chan_sel(chan),
    .auto_sw_one(sw1), .auto_sw_two(sw2), .relay_ovr_en(ov_en), .relay_ovr_state(ov_st),
    .relay_rev_pol(rev), .ion_line_mant(7'(lm[0])), .ion_line_exp(6'(le[0])),
    .line_a_mant(7'(lm[1])), .line_a_exp(6'(le[1])), .line_b_mant(7'(lm[2])),
    .line_b_exp(6'(le[2])), .turn_on_one_mant(7'h32), .turn_on_one_exp(6'h3d),
    .turn_on_two_mant(7'h14), .turn_on_two_exp(6'h3c), .ion_gauge_one_on(g_on[0]),
    .ion_gauge_two_on(g_on[1]), .auto_on_req(on_req), .auto_off_req(off_req), .relay(relay),
    .ion_line_src(src[0]), .ion_line_out_mant(om[0]), .ion_line_out_exp(oe[0]),
    .line_a_src(src[1]), .line_a_out_mant(om[1]), .line_a_out_exp(oe[1]),
    .line_b_src(src[2]), .line_b_out_mant(om[2]), .line_b_out_exp(oe[2]));
  psc_partner i_partner (.core_clk(core_clk), .nrst(nrst), .on_req(on_req),
    .off_req(off_req), .manual_off(man_off), .gauge_on(g_on));
  always #25 core_clk = ~core_clk;
  // ==========================================================
  // Helpers and model
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] expv);
    checks_done++;
    if (seen !== expv) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
    end
  endtask
  function automatic int kf(input int m, input int e);
    return (m == 0) ? 0 : (e + 12) * 90 + m - 9;
  endfunction
  function automatic logic [5:0] rel_exp();
    logic [5:0] r;
    for (int i = 0; i < 6; i++) begin
      r[i] = ov_en[i] ? ov_st[i] : ((kf(lm[i/2], le[i/2]) < kf(spm[i+1], spe[i+1])) ^ rev[i]);
    end
    return r;
  endfunction
  task automatic astep(input int g, input int m, input int e, input logic [1:0] sw);
    int t;
    int ton;
    ton = (g == 0) ? kf(50, -3) : kf(20, -4);
    if (g == 0) sw1 = sw;
    else sw2 = sw;
    tick(5);
    lm[g+1] = m;
    le[g+1] = e;
    t = kf(m, e);
    if (t < ton && flag[g] == 0) begin
      flag[g] = 1;
      eon[g] += int'(sw == AUTO_ON);
    end
    if (t > ton + 5 && flag[g] == 1) begin
      flag[g] = 0;
      eoff[g] += int'(sw == AUTO_ON && g_on[g]);
    end
    tick(10);
    for (int k = 0; k < 2; k++) begin
      check("auto_on", 16'(non[k]), 16'(eon[k]));
      check("auto_off", 16'(noff[k]), 16'(eoff[k]));
    end
  endtask
  task automatic wait_src(input int l, input logic [1:0] s, input int lim, output int n);
    n = 0;
    while (src[l] !== s && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic wait_chg(input int lim, output int n);
    logic [12:0] v;
    v = {om[1], oe[1]};
    n = 0;
    while ({om[1], oe[1]} === v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  always @(posedge core_clk) begin
    if (nrst) begin
      for (int g = 0; g < 2; g++) begin
        non[g] += int'(on_req[g]);
        noff[g] += int'(off_req[g]);
      end
      check("pulse_len", 16'((on_req & p_on) | (off_req & p_off)), 16'h0);
    end
    p_on <= on_req;
    p_off <= off_req;
  end
  task automatic conclude();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge core_clk);
    failures++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    tick(10);
    repeat (4) begin
      ov_en = 6'($random(seed));
      ov_st = 6'($random(seed));
      rev = 6'($random(seed));
      tick(12);
      check("relay", 16'(relay), 16'(rel_exp()));
    end
    ov_en = 6'h00;
    rev = 6'h00;
    for (int i = 0; i < 10; i++) begin
      if (i == 5) begin
        man_off = 2'h1;
        tick(2);
        man_off = 2'h0;
      end
      astep(0, tm[i], -3, (i < 8) ? AUTO_ON : AUTO_OFF);
    end
    sw1 = AUTO_SET;
    sw2 = AUTO_SET;
    tick(8);
    check("ton_a", 16'({src[1], om[1], oe[1]}), 16'({PSC_SRC_TURNON, 7'h32, 6'h3d}));
    check("ton_b", 16'({src[2], om[2], oe[2]}), 16'({PSC_SRC_TURNON, 7'h14, 6'h3c}));
    sw1 = AUTO_OFF;
    astep(1, 10, -4, AUTO_ON);
    astep(1, 30, -4, AUTO_ON);
    chan = 3'h3;
    up = 1'b1;
    wait_src(1, PSC_SRC_SETPT, 50, el);
    check("first_val", 16'(om[1]), 16'(MANT_ZERO));
    wait_chg(25000, el);
    check("hold_time", 16'(el > 19900 && el < 22100), 16'h1);
    check("step_min", 16'({om[1], oe[1]}), 16'({MANT_MIN, EXP_MIN}));
    wait_chg(2100, el);
    wait_chg(2100, el);
    check("slow_step", 16'(el > 1990 && el < 2010), 16'h1);
    check("step_val", 16'({om[1], oe[1]}), 16'({7'h0c, EXP_MIN}));
    up = 1'b0;
    wait_src(1, PSC_SRC_PRESS, 8200, el);
    check("commit_time", 16'(el > 7900 && el < 8100), 16'h1);
    spm[3] = 12;
    spe[3] = -12;
    for (int i = 0; i < 6; i++) begin
      lm[1] = 11 + i % 3;
      le[1] = -12;
      rev = (i > 2) ? 6'h3f : 6'h00;
      tick(12);
      check("relay", 16'(relay), 16'(rel_exp()));
      check("press_a", 16'({om[1], oe[1]}), 16'({7'(lm[1]), 6'(le[1])}));
    end
    rev = 6'h00;
    for (int c = 0; c < 7; c++) begin
      ln = (c < 3) ? 0 : (c < 5) ? 1 : 2;
      chan = 3'(c);
      tick(5);
      if (c % 2 == 1) up = 1'b1;
      else dn = 1'b1;
      tick(10);
      up = 1'b0;
      dn = 1'b0;
      wait_src(ln, PSC_SRC_SETPT, 40, el);
      check("show_src", 16'(el < 40), 16'(c != 0));
      if (c != 0) begin
        check("show_val", 16'({om[ln], oe[ln]}), 16'({7'(spm[c]), 6'(spe[c])}));
        check("other_src", 16'(src[(ln+1)%3] | src[(ln+2)%3]), 16'(PSC_SRC_PRESS));
        wait_src(ln, PSC_SRC_PRESS, 8200, el);
        check("show_time", 16'(el > 7900 && el < 8020), 16'h1);
      end
    end
    conclude();
  end
endmodule
